// *** rtl/sff_top.sv ***
/*
 * Sequencer fault flags: sticky W1C flags, interrupt and reset routing,
 * and the trigger and slot logic that steps the output enables.
 * Assumes an APB master on the same clock and synchronous pin inputs.
 */
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sff_regs.svh"

module sff_top #(
    parameter int N_RAILS = 4
) (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // fault and event sources
    input  wire sff_pkg::sff_event_s  events,
    // trigger pins
    input  wire logic                 active_in,
    input  wire logic                 sleep_in,
    input  wire logic                 power_button_n,
    input  wire logic                 emergency_pd_in_n,
    input  wire logic                 external_reset_in_n,
    // outputs
    output logic [N_RAILS-1:0]        rail_enable_out,
    output logic                      slow_clock_out,
    output logic                      interrupt_out_n,
    output logic                      reset_out_n
);
    import sff_pkg::*;

    localparam int NOUT   = N_RAILS + 1;
    localparam int SLOT_W = 4 * NOUT;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [`SFF_NFLAGS-1:0] flags;
    logic [`SFF_NFLAGS-1:0] mask;
    logic [5:0]             config_r;
    logic [4*NOUT-1:0]      slots;
    logic [`SFF_NFLAGS-1:0] set_vec;
    logic [`SFF_NFLAGS-1:0] clr_vec;
    logic [`SFF_NFLAGS-1:0] rst_route;
    logic                   wr_en;
    logic                   rd_setup;
    logic [31:0]            next_rdata;
    logic                   next_err;
    logic                   mapped;
    logic                   active_q;
    logic                   sleep_q;
    logic                   empd_q;
    logic                   xrst_q;
    logic                   up_trig;
    logic                   down_trig;
    logic                   fshdn_trig;
    sff_seq_e               state;
    logic                   dir_up;
    logic [3:0]             slot;
    logic [15:0]            timer;
    logic                   slot_tick;
    logic [NOUT-1:0]        out_lvl;
    logic [NOUT-1:0]        next_lvl;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign wr_en    = psel & penable & pready & pwrite & ~pslverr;
    assign rd_setup = psel & ~penable;

    always_comb
    begin
        mapped     = 1'b1;
        next_rdata = 32'h0000_0000;
        case (paddr)
            `SFF_OFS_FLAGS:  next_rdata[`SFF_NFLAGS-1:0] = flags;
            `SFF_OFS_MASK:   next_rdata[`SFF_NFLAGS-1:0] = mask;
            `SFF_OFS_CONFIG: next_rdata[5:0] = config_r;
            `SFF_OFS_STATUS: next_rdata = {22'h000000, (state == SFF_RUN), dir_up, slot,
                                           ~reset_out_n, ~interrupt_out_n, 2'b00};
            `SFF_OFS_SLOTS:  next_rdata[4*NOUT-1:0] = slots;
            default:         mapped = 1'b0;
        endcase
        next_err = ~mapped;
    end

    // zero-wait slave: answer in the first access cycle
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= rd_setup;
            pslverr <= rd_setup & next_err;
            if (rd_setup & ~pwrite)
                prdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mask     <= `SFF_MASK_RST;
            config_r <= `SFF_CONFIG_RST;
            slots    <= SLOT_W'(`SFF_SLOTS_RST);
        end
        else if (wr_en)
        begin
            if (paddr == `SFF_OFS_MASK)
                mask <= pwdata[`SFF_NFLAGS-1:0];
            if (paddr == `SFF_OFS_CONFIG)
                config_r <= pwdata[5:0];
            if (paddr == `SFF_OFS_SLOTS)
                slots <= pwdata[4*NOUT-1:0];
        end
    end

    // ----------------------------------------------------------------
    // sticky flags
    // ----------------------------------------------------------------
    always_comb
    begin
        set_vec = '0;
        // (R2) emergency power-down
        set_vec[`SFF_B_EMPD]    = events.emergency_pd;
        // (R3) watchdog violation
        set_vec[`SFF_B_WDOG]    = events.watchdog;
        // (R4) packet check miscompare
        set_vec[`SFF_B_PEC]     = events.packet_check;
        set_vec[`SFF_B_ALARM]   = events.alarm;
        // (R5) enable readback fault
        set_vec[`SFF_B_ENABLE]  = events.enable_readback;
        set_vec[`SFF_B_OSC]     = events.oscillator;
        // (R6) pin readback mismatch
        set_vec[`SFF_B_PINS]    = events.pin_readback;
        // (R7) self test failure
        set_vec[`SFF_B_BIST]    = events.self_test;
        set_vec[`SFF_B_LDO]     = events.regulator;
        set_vec[`SFF_B_THERMAL] = events.thermal;
        // (R8) crc checker only sets
        set_vec[`SFF_B_CRC]     = events.register_crc;
        // (R9) uncorrectable load error
        set_vec[`SFF_B_DED]     = events.double_error;
        // (R10) button short press
        set_vec[`SFF_B_PRESS]   = events.short_press;
        // (R1) any source, aggregate flag
        set_vec[`SFF_B_INTERNAL] = |set_vec;
    end

    assign clr_vec = (wr_en && paddr == `SFF_OFS_FLAGS) ? pwdata[`SFF_NFLAGS-1:0] : '0;

    // (R13) set wins over a same-cycle clear
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            flags <= '0;
        else
            flags <= (flags & ~clr_vec) | set_vec;
    end

    // ----------------------------------------------------------------
    // interrupt and reset outputs
    // ----------------------------------------------------------------
    // (R3) watchdog reaches reset only when configured
    always_comb
    begin
        rst_route = `SFF_RST_ROUTE;
        rst_route[`SFF_B_WDOG] = config_r[`SFF_C_WDOG_RST];
    end

    // mask gates the interrupt only; reset routing cannot be masked
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            interrupt_out_n <= 1'b1;
            reset_out_n     <= 1'b0;
        end
        else
        begin
            // (R13) interrupt held while flag set
            interrupt_out_n <= ~|(flags & mask);
            // (R5) reset from routed flags
            reset_out_n     <= ~|(flags & rst_route);
        end
    end

    // ----------------------------------------------------------------
    // sequencing triggers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            active_q <= 1'b0;
            sleep_q  <= 1'b0;
            empd_q   <= 1'b1;
            xrst_q   <= 1'b1;
        end
        else
        begin
            active_q <= active_in;
            sleep_q  <= sleep_in;
            empd_q   <= emergency_pd_in_n;
            xrst_q   <= external_reset_in_n;
        end
    end

    assign fshdn_trig = wr_en && paddr == `SFF_OFS_CONFIG && pwdata[`SFF_C_FSHDN_LO+1:`SFF_C_FSHDN_LO] != 2'b00;

    // (R11) hardware and software triggers
    assign up_trig   = (active_in & ~active_q) | (sleep_in & ~sleep_q) | events.alarm
                     | (config_r[`SFF_C_BTN_EN] & ~power_button_n & events.short_press);
    assign down_trig = (~active_in & active_q) | (~sleep_in & sleep_q) | fshdn_trig
                     | (config_r[`SFF_C_EMPD_EN] & ~emergency_pd_in_n & empd_q)
                     | (config_r[`SFF_C_XRST_EN] & ~external_reset_in_n & xrst_q);

    // ----------------------------------------------------------------
    // slot sequencer
    // ----------------------------------------------------------------
    assign slot_tick = (state == SFF_RUN) && timer == 16'h0000;

    // down wins when both arrive together, the safer direction
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state  <= SFF_IDLE;
            dir_up <= 1'b0;
            slot   <= 4'h0;
            timer  <= 16'h0000;
        end
        else if (up_trig | down_trig)
        begin
            state  <= SFF_RUN;
            dir_up <= ~down_trig;
            slot   <= 4'h0;
            timer  <= 16'(`SFF_SLOT_CYC - 1);
        end
        else
        begin
            case (state)
                SFF_IDLE:
                begin
                    timer <= 16'h0000;
                end
                SFF_RUN:
                begin
                    if (slot_tick)
                    begin
                        slot  <= slot + 4'h1;
                        timer <= 16'(`SFF_SLOT_CYC - 1);
                        if (slot + 4'h1 == `SFF_LAST_SLOT)
                            state <= SFF_IDLE;
                    end
                    else
                        timer <= timer - 16'h0001;
                end
                default:
                begin
                    state <= SFF_IDLE;
                end
            endcase
        end
    end

    // per output: field 0 never moves, field 1 moves at the first slot end
    genvar g;
    generate
        for (g = 0; g < NOUT; g++)
        begin : g_out
            // (R12) slot one is first after trigger
            assign next_lvl[g] = (slot_tick && slots[4*g +: 4] == slot + 4'h1) ? dir_up : out_lvl[g];
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            out_lvl <= '0;
        else
            out_lvl <= next_lvl;
    end

    // slow clock is shown as its gate level only
    assign rail_enable_out = out_lvl[N_RAILS-1:0];
    assign slow_clock_out  = out_lvl[N_RAILS];

endmodule
`default_nettype wire

// *** rtl/sff_regs.svh ***
/*
 * Constants of the sequencer fault-flag block: register offsets, flag bit
 * positions, reset values and slot timing.
 * Assumes a 40 MHz system clock and 32-bit APB register access.
 */
// Functional notes
// (R1) Any interrupt source firing also sets the internal fault flag, which drives the interrupt and is cleared by writing one.
// (R2) An emergency power-down sets its flag, which pulls both the reset output and the interrupt output.
// (R3) A watchdog violation sets its flag; it drives the interrupt, and the reset output only when configured to.
// (R4) A packet check miscompare on the serial bus sets its flag, which drives the interrupt output.
// (R5) A faulty enable-output readback sets its flag, which drives both interrupt and reset outputs.
// (R6) A reset or interrupt pin readback mismatch sets its flag, which drives only the interrupt output.
// (R7) A failed self test sets its flag, which drives both interrupt and reset outputs.
// (R8) A register CRC fault sets its flag and drives the interrupt; only the host clears it.
// (R9) An uncorrectable memory error on load sets its flag, which drives both interrupt and reset outputs.
// (R10) A short press on the power button sets its flag, which drives both reset and interrupt outputs.
// (R11) Sequencing starts on active, sleep, alarm wake, forced shutdown, and enabled button, power-down or reset inputs.
// (R12) Slot one is the earliest slot; an output assigned to it toggles in the first slot after the trigger.
// (R13) Each flag stays set until the host writes one to it, and the interrupt holds while a routed flag is set.
`ifndef SFF_REGS_SVH
`define SFF_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SFF_OFS_FLAGS     12'h000
`define SFF_OFS_MASK      12'h004
`define SFF_OFS_CONFIG    12'h008
`define SFF_OFS_STATUS    12'h00C
`define SFF_OFS_SLOTS     12'h010

// ----------------------------------------------------------------
// flag bit positions
// ----------------------------------------------------------------
`define SFF_NFLAGS        14
`define SFF_B_INTERNAL    0
`define SFF_B_EMPD        1
`define SFF_B_WDOG        2
`define SFF_B_PEC         3
`define SFF_B_ALARM       4
`define SFF_B_ENABLE      5
`define SFF_B_OSC         6
`define SFF_B_PINS        7
`define SFF_B_BIST        8
`define SFF_B_LDO         9
`define SFF_B_THERMAL     10
`define SFF_B_CRC         11
`define SFF_B_DED         12
`define SFF_B_PRESS       13
// flags that also pull the reset output (watchdog added by config)
`define SFF_RST_ROUTE     14'h3722

// ----------------------------------------------------------------
// config fields and reset values
// ----------------------------------------------------------------
`define SFF_C_WDOG_RST    0
`define SFF_C_BTN_EN      1
`define SFF_C_EMPD_EN     2
`define SFF_C_XRST_EN     3
`define SFF_C_FSHDN_LO    4
`define SFF_MASK_RST      14'h3FFF
`define SFF_CONFIG_RST    6'h00
`define SFF_SLOTS_RST     20'h54321

// ----------------------------------------------------------------
// slot timing
// ----------------------------------------------------------------
`define SFF_CLK_NS        25
`define SFF_SLOT_NS       1000
`define SFF_SLOT_CYC      ((`SFF_SLOT_NS + `SFF_CLK_NS - 1) / `SFF_CLK_NS)
`define SFF_LAST_SLOT     4'hF

`endif

// *** rtl/sff_pkg.sv ***
/*
 * Types of the sequencer fault-flag block.
 * Assumes sff_regs.svh for the numeric constants.
 */
package sff_pkg;

    // ----------------------------------------------------------------
    // fault and event sources, each a one-cycle pulse
    // ----------------------------------------------------------------
    typedef struct packed {
        logic short_press;
        logic double_error;
        logic register_crc;
        logic thermal;
        logic regulator;
        logic self_test;
        logic pin_readback;
        logic oscillator;
        logic enable_readback;
        logic alarm;
        logic packet_check;
        logic watchdog;
        logic emergency_pd;
    } sff_event_s;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SFF_IDLE = 2'b01,
        SFF_RUN  = 2'b10
    } sff_seq_e;

endpackage

// *** verif/sff_props.sv ***
/* checker of sff_top flag and pin routing.
   assumes binding to sff_top ports; mask bit 0 stays enabled. */
`timescale 1ns/1ps
`default_nettype none
module sff_props
    import sff_pkg::*;
(
    // watched ports
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire sff_event_s events,
    input wire logic       interrupt_out_n,
    input wire logic       reset_out_n
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    wire logic wr_acc = psel && penable && pwrite;
    // ------------------------------------------------------------
    // routing of flags to pins
    // ------------------------------------------------------------
    property p_any_irq;
        |events |-> ##2 !interrupt_out_n;
    endproperty
    a_any_irq: assert property (p_any_irq) else $error("no irq after event");
    property p_empd_rst;
        events.emergency_pd |-> ##2 !reset_out_n && !interrupt_out_n;
    endproperty
    a_empd_rst: assert property (p_empd_rst) else $error("emergency_powerdown_flag not routed");
    property p_wdog_irq;
        events.watchdog |-> ##2 !interrupt_out_n;
    endproperty
    a_wdog_irq: assert property (p_wdog_irq) else $error("wdog no irq");
    property p_pec_irq;
        events.packet_check |-> ##2 (!interrupt_out_n) [*2];
    endproperty
    a_pec_irq: assert property (p_pec_irq) else $error("pec no irq");
    property p_en_rst;
        events.enable_readback |=> ##1 !reset_out_n;
    endproperty
    a_en_rst: assert property (p_en_rst) else $error("enable fault no reset");
    property p_crc_irq;
        events.register_crc ##1 1'b1 |=> !interrupt_out_n;
    endproperty
    a_crc_irq: assert property (p_crc_irq) else $error("crc no irq");
    property p_press_rst;
        events.short_press |-> ##2 !reset_out_n;
    endproperty
    a_press_rst: assert property (p_press_rst) else $error("press no reset");
    // only a host write may lift the interrupt
    property p_irq_hold;
        !interrupt_out_n && !wr_acc && !$past(wr_acc) |=> !interrupt_out_n;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
endmodule
`default_nettype wire

// *** verif/sff_host.sv ***
/* apb host model driving sff_top registers.
   assumes the design answers with pready; bench timeout ends hangs. */
`timescale 1ns/1ps
`default_nettype none
module sff_host (
    // apb
    input wire logic        sys_clk,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [11:0]     paddr,
    output logic [31:0]     pwdata
);
    initial
    begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        // random idle gap: a slow host as well as a prompt one
        repeat ($urandom % 3) @(posedge sys_clk);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // ready, read data and error all taken at one rising edge
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// *** verif/sequencer_fault_flags_test.sv ***
/* self-checking bench of sff_top against an integer model.
   assumes sff_host and sff_props beside it. */
`timescale 1ns/1ps
`default_nettype none
`include "sff_regs.svh"
module sequencer_fault_flags_test;
    import sff_pkg::*;
    logic        sys_clk = 0, rstn = 0, active_in = 0;
    logic        sleep_in = 0, btn_n = 1, empd_n = 1, xrst_n = 1;
    logic        psel, penable, pwrite, pready, pslverr, irq_n, rst_n, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [3:0]  rails;
    logic        e;
    sff_event_s  events = '0;
    int          n_fail = 0, checked = 0, flg = 0, msk = 32'h3FFF, cfg = 0, n0, n1;
    always #12.5 sys_clk = ~sys_clk;
    sff_host u_sff_host (.sys_clk(sys_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    sff_top u_sff_top (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .events(events), .active_in(active_in), .sleep_in(sleep_in),
        .power_button_n(btn_n), .emergency_pd_in_n(empd_n), .external_reset_in_n(xrst_n),
        .rail_enable_out(rails), .slow_clock_out(slow), .interrupt_out_n(irq_n), .reset_out_n(rst_n));
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checked++;
        if (got !== ex)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, ex, got);
        end
    endtask
    // pins after two edges, then flag register
    task automatic state_chk;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("irq_n", 32'((flg & msk) == 0), {31'h0, irq_n});
        chk("rst_n", 32'((flg & (`SFF_RST_ROUTE | (cfg << 2))) == 0), {31'h0, rst_n});
        u_sff_host.xfer(1'b0, `SFF_OFS_FLAGS, 32'h0, d, e);
        chk("flags", flg, d);
    endtask
    // all sequenced outputs, sampled away from the launching edge
    task automatic wait_outs(input logic [4:0] want, input string nm);
        for (int k = 0; {slow, rails} !== want && k < 900; k++) @(negedge sys_clk);
        chk(nm, {27'h0, want}, {27'h0, slow, rails});
    endtask
    task automatic final_report;
        if (n_fail == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #(25 * 40000);
        n_fail++;
        final_report();
    end
    initial
    begin
        void'($urandom(30));
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        state_chk();
        u_sff_host.xfer(1'b0, `SFF_OFS_MASK, 32'h0, d, e);
        chk("mask", 32'h3FFF, d);
        u_sff_host.xfer(1'b0, `SFF_OFS_STATUS, 32'h0, d, e);
        chk("status", 32'h0, d);
        u_sff_host.xfer(1'b0, `SFF_OFS_SLOTS, 32'h0, d, e);
        chk("slots", `SFF_SLOTS_RST, d);
        u_sff_host.xfer(1'b0, 12'h100, 32'h0, d, e);
        chk("unmapped", 32'h1, {31'h0, e});
        for (int i = 0; i < 13; i++)
        begin
            cfg = $urandom % 2;
            msk = ($urandom & 32'h3FFE) | 1;
            u_sff_host.xfer(1'b1, `SFF_OFS_CONFIG, cfg, d, e);
            u_sff_host.xfer(1'b1, `SFF_OFS_MASK, msk, d, e);
            @(posedge sys_clk);
            events <= sff_event_s'(13'h1 << i);
            @(posedge sys_clk);
            events <= '0;
            flg = flg | (2 << i) | 1;
            state_chk();
            u_sff_host.xfer(1'b1, `SFF_OFS_FLAGS, 32'h0, d, e);
            state_chk();
            u_sff_host.xfer(1'b1, `SFF_OFS_FLAGS, 32'h1, d, e);
            flg = flg & ~1;
            state_chk();
            u_sff_host.xfer(1'b1, `SFF_OFS_FLAGS, flg, d, e);
            flg = 0;
            state_chk();
        end
        // second reset mid-run: the alarm event left outputs raised
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        msk = 32'h3FFF;
        cfg = 0;
        state_chk();
        // first slot timing, then gap to slot two
        @(posedge sys_clk);
        active_in <= 1'b1;
        for (n0 = 0; rails[0] !== 1'b1 && n0 < 200; n0++) @(negedge sys_clk);
        for (n1 = n0; rails[1] !== 1'b1 && n1 < 300; n1++) @(negedge sys_clk);
        chk("slot1_near", 32'h1, 32'(n0 >= `SFF_SLOT_CYC && n0 <= `SFF_SLOT_CYC + 3));
        chk("slot_gap", `SFF_SLOT_CYC, n1 - n0);
        for (int k = 0; slow !== 1'b1 && k < 300; k++) @(negedge sys_clk);
        chk("slow_up", 32'h1, {31'h0, slow});
        u_sff_host.xfer(1'b1, `SFF_OFS_CONFIG, 32'h10, d, e);
        wait_outs(5'h00, "outs_down");
        // pin triggers, button, power-down and reset inputs enabled
        u_sff_host.xfer(1'b1, `SFF_OFS_CONFIG, 32'h0E, d, e);
        sleep_in <= 1'b1;
        wait_outs(5'h1F, "sleep_up");
        @(posedge sys_clk);
        empd_n <= 1'b0;
        wait_outs(5'h00, "empd_down");
        @(posedge sys_clk);
        empd_n <= 1'b1;
        btn_n <= 1'b0;
        events.short_press <= 1'b1;
        @(posedge sys_clk);
        events <= '0;
        wait_outs(5'h1F, "button_up");
        @(posedge sys_clk);
        btn_n <= 1'b1;
        xrst_n <= 1'b0;
        wait_outs(5'h00, "xrst_down");
        final_report();
    end
endmodule
bind sff_top sff_props u_sff_props (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .events(events), .interrupt_out_n(interrupt_out_n), .reset_out_n(reset_out_n));
`default_nettype wire
